// File: hss_pkg.sv
package hss_pkg;

  // Output configuration codes for each switch's 3-bit field.
  localparam logic [2:0] CFG_OFF = 3'h0;
  localparam logic [2:0] CFG_ON = 3'h1;
  localparam logic [2:0] CFG_TIMER1 = 3'h2;
  localparam logic [2:0] CFG_TIMER2 = 3'h3;
  localparam logic [2:0] CFG_PWM1 = 3'h4;
  localparam logic [2:0] CFG_PWM2 = 3'h5;

  localparam int NUM_OUT = 4;
  localparam int CFG_W = 3;
  localparam int DUTY_W = 8;

  // Clock rate and PWM frequencies.
  localparam longint CLK_HZ = 100000000;
  localparam longint PWM_SLOW_HZ = 200;
  localparam longint PWM_FAST_HZ = 400;
  localparam int STEP_SLOW_CYC = int'(CLK_HZ / (PWM_SLOW_HZ * 256));
  localparam int STEP_FAST_CYC = int'(CLK_HZ / (PWM_FAST_HZ * 256));
  localparam int STEP_W = 12;

  // Filter times in nanoseconds, and their cycle counts (least time, rounded up).
  localparam longint CLK_PERIOD_NS = 10;
  localparam longint OC_FILTER_NS = 16000;
  localparam longint OL_FILTER_NS = 64000;
  localparam int OC_FILTER_CYC = int'((OC_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int OL_FILTER_CYC = int'((OL_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int FILT_W = 16;

  // Reset values.
  localparam logic [2:0] CFG_RESET = 3'h0;
  localparam logic [7:0] DUTY_RESET = 8'h00;

  // Device operating modes.
  typedef enum logic [4:0] {
    MODE_NORMAL = 5'h01,
    MODE_STOP = 5'h02,
    MODE_SLEEP = 5'h04,
    MODE_RESTART = 5'h08,
    MODE_FAILSAFE = 5'h10
  } mode_type;

endpackage

// File: pulse_gen.sv
// One 8-bit PWM generator with a selectable period.
module pulse_gen (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic fastSel,
  input wire logic [7:0] duty,
  output logic pwmOut
);

  logic [hss_pkg::STEP_W-1:0] prescale_ff;
  logic [7:0] phase_ff;
  logic pwm_ff;
  logic [hss_pkg::STEP_W-1:0] stepLen;
  logic stepDone;

  // Step length follows the frequency select.
  assign stepLen = fastSel ? hss_pkg::STEP_W'(hss_pkg::STEP_FAST_CYC - 1)
                           : hss_pkg::STEP_W'(hss_pkg::STEP_SLOW_CYC - 1);
  assign stepDone = (prescale_ff >= stepLen);

  // Free-running period counter: 256 steps make one period.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prescale_ff <= '0;
      phase_ff <= 8'h00;
      pwm_ff <= 1'b0;
    end else if (clkEn) begin
      prescale_ff <= stepDone ? '0 : prescale_ff + hss_pkg::STEP_W'(1);
      if (stepDone) begin
        phase_ff <= phase_ff + 8'h01;
      end
      pwm_ff <= (phase_ff < duty);
    end
  end

  assign pwmOut = pwm_ff;

endmodule

// File: fault_filter.sv
// Two-flop synchroniser and a persistence filter for one comparator input.
module fault_filter #(
  parameter int COUNT = 16
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic arm,
  input wire logic rawIn,
  output logic syncOut,
  output logic tripped
);

  logic meta_ff;
  logic sync_ff;
  logic [hss_pkg::FILT_W-1:0] count_ff;

  // Synchronise first; only the second flop is read.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else if (clkEn) begin
      meta_ff <= rawIn;
      sync_ff <= meta_ff;
    end
  end

  // Count while the condition holds and the channel is armed.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_ff <= '0;
    end else if (clkEn) begin
      if (!(sync_ff && arm)) begin
        count_ff <= '0;
      end else if (count_ff != hss_pkg::FILT_W'(COUNT)) begin
        count_ff <= count_ff + hss_pkg::FILT_W'(1);
      end
    end
  end

  assign syncOut = sync_ff;
  assign tripped = (count_ff == hss_pkg::FILT_W'(COUNT));

endmodule

// File: high_side_switch_control.sv
//
// Contract
// - Overvoltage forces outputs off unless disabled
// - Overvoltage release reactivates forced-off outputs only with recovery bit set
// - Undervoltage forces outputs off unless disabled
// - Recovery bit chooses restore or clear
// - Supply faults set only supply flags
// - Filtered overcurrent switches output off
// - Overcurrent sets flag, config becomes 000
// - Overcurrent flags stay until software clears
// - Open load flags, output stays on
// - Open-load flags sticky until software clear
// - Configuration writable only in normal mode
// - Restart or fail-safe turns outputs off
// - Protections stay active in stop, sleep
// - Output selects on, off, timers, PWMs
// - Two PWM generators, 8-bit duty each
// - Each generator runs 200Hz or 400Hz
// - PWM starts once output is assigned
// - Tiny duty may show no pulse
//
module high_side_switch_control (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire hss_pkg::mode_type devMode,
  input wire logic cfgWrite,
  input wire logic [1:0] cfgSel,
  input wire logic [2:0] cfgData,
  input wire logic dutyWriteA,
  input wire logic dutyWriteB,
  input wire logic [7:0] dutyData,
  input wire logic freqWrite,
  input wire logic [1:0] freqData,
  input wire logic ctlWrite,
  input wire logic ovCutoffDisable,
  input wire logic uvCutoffDisable,
  input wire logic recoveryEnable,
  input wire logic ocClear,
  input wire logic [3:0] ocClearMask,
  input wire logic olClear,
  input wire logic [3:0] olClearMask,
  input wire logic supplyClear,
  input wire logic timer1In,
  input wire logic timer2In,
  input wire logic supplyOvRaw,
  input wire logic supplyUvRaw,
  input wire logic [3:0] overCurrentRaw,
  input wire logic [3:0] underCurrentRaw,
  output logic [3:0] outputSwitchN,
  output logic [3:0] overcurrentStatusReg,
  output logic [3:0] openLoadStatusReg,
  output logic supplyOvervoltageFlag,
  output logic supplyUndervoltageFlag,
  output logic [11:0] outputConfigState,
  output logic [7:0] pulseGenADutyOut,
  output logic [7:0] pulseGenBDutyOut,
  output logic [1:0] pulseGenFrequencySelect
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [2:0] cfg_ff [hss_pkg::NUM_OUT];
  logic [7:0] dutyA_ff;
  logic [7:0] dutyB_ff;
  logic [1:0] freq_ff;
  logic ovDis_ff;
  logic uvDis_ff;
  logic recEn_ff;
  logic [3:0] oc_ff;
  logic [3:0] ol_ff;
  logic supOv_ff;
  logic supUv_ff;
  logic supFault_ff;
  logic [3:0] sw_ff;
  logic [11:0] cfgOut_ff;
  logic [7:0] dutyAOut_ff;
  logic [7:0] dutyBOut_ff;
  logic [1:0] freqOut_ff;

  logic pwmA;
  logic pwmB;
  logic ovSync;
  logic uvSync;
  logic ovTrip;
  logic uvTrip;
  logic [3:0] ocSync;
  logic [3:0] olSync;
  logic [3:0] ocTrip;
  logic [3:0] olTrip;
  logic [3:0] demand;
  logic inNormal;
  logic offMode;
  logic supplyCut;
  logic supplyRelease;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration code to switch demand.

  // Maps one configuration field onto the requested switch level.
  function automatic logic cfgDemand(input logic [2:0] code, input logic t1, input logic t2,
                                     input logic p1, input logic p2);
    logic lvl;
    lvl = 1'b0;
    case (code)
      hss_pkg::CFG_ON: lvl = 1'b1;
      hss_pkg::CFG_TIMER1: lvl = t1;
      hss_pkg::CFG_TIMER2: lvl = t2;
      hss_pkg::CFG_PWM1: lvl = p1;
      hss_pkg::CFG_PWM2: lvl = p2;
      default: lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // PWM generators and comparator filters.

  pulse_gen genA (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .fastSel(freq_ff[0]),
    .duty(dutyA_ff),
    .pwmOut(pwmA)
  );

  pulse_gen genB (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .fastSel(freq_ff[1]),
    .duty(dutyB_ff),
    .pwmOut(pwmB)
  );

  fault_filter #(.COUNT(1)) ovFilt (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .arm(1'b1),
    .rawIn(supplyOvRaw),
    .syncOut(ovSync),
    .tripped(ovTrip)
  );

  fault_filter #(.COUNT(1)) uvFilt (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .arm(1'b1),
    .rawIn(supplyUvRaw),
    .syncOut(uvSync),
    .tripped(uvTrip)
  );

  for (genvar i = 0; i < hss_pkg::NUM_OUT; i++) begin : g_chan
    fault_filter #(.COUNT(hss_pkg::OC_FILTER_CYC)) ocFilt (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .arm(sw_ff[i]),
      .rawIn(overCurrentRaw[i]),
      .syncOut(ocSync[i]),
      .tripped(ocTrip[i])
    );
    fault_filter #(.COUNT(hss_pkg::OL_FILTER_CYC)) olFilt (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .arm(sw_ff[i]),
      .rawIn(underCurrentRaw[i]),
      .syncOut(olSync[i]),
      .tripped(olTrip[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode and supply decode.

  // Only normal mode accepts writes; restart and fail-safe force off.
  assign inNormal = (devMode == hss_pkg::MODE_NORMAL);
  assign offMode = (devMode == hss_pkg::MODE_RESTART) || (devMode == hss_pkg::MODE_FAILSAFE);
  assign supplyCut = (ovTrip && !ovDis_ff) || (uvTrip && !uvDis_ff);
  // Falling edge of the combined cut marks the release point.
  assign supplyRelease = supFault_ff && !supplyCut;

  for (genvar j = 0; j < hss_pkg::NUM_OUT; j++) begin : g_dem
    assign demand[j] = cfgDemand(cfg_ff[j], timer1In, timer2In, pwmA, pwmB);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  // Writes land only in normal mode; hardware clears win over software.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int k = 0; k < hss_pkg::NUM_OUT; k++) begin
        cfg_ff[k] <= hss_pkg::CFG_RESET;
      end
    end else if (clkEn) begin
      for (int k = 0; k < hss_pkg::NUM_OUT; k++) begin
        if (cfgWrite && inNormal && (cfgSel == 2'(k))) begin
          cfg_ff[k] <= cfgData;
        end
        if (supplyRelease && !recEn_ff) begin
          cfg_ff[k] <= hss_pkg::CFG_OFF;
        end
        if (ocTrip[k]) begin
          cfg_ff[k] <= hss_pkg::CFG_OFF;
        end
        if (offMode) begin
          cfg_ff[k] <= hss_pkg::CFG_OFF;
        end
      end
    end
  end

  // Duty, frequency and cutoff controls, normal mode only.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dutyA_ff <= hss_pkg::DUTY_RESET;
      dutyB_ff <= hss_pkg::DUTY_RESET;
      freq_ff <= 2'h0;
      ovDis_ff <= 1'b0;
      uvDis_ff <= 1'b0;
      recEn_ff <= 1'b0;
    end else if (clkEn && inNormal) begin
      if (dutyWriteA) begin
        dutyA_ff <= dutyData;
      end
      if (dutyWriteB) begin
        dutyB_ff <= dutyData;
      end
      if (freqWrite) begin
        freq_ff <= freqData;
      end
      if (ctlWrite) begin
        ovDis_ff <= ovCutoffDisable;
        uvDis_ff <= uvCutoffDisable;
        recEn_ff <= recoveryEnable;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags; a set in the clear cycle wins.

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      oc_ff <= 4'h0;
      ol_ff <= 4'h0;
      supOv_ff <= 1'b0;
      supUv_ff <= 1'b0;
    end else if (clkEn) begin
      oc_ff <= (oc_ff & ~(ocClear ? ocClearMask : 4'h0)) | ocTrip;
      ol_ff <= (ol_ff & ~(olClear ? olClearMask : 4'h0)) | olTrip;
      supOv_ff <= (supOv_ff && !supplyClear) || ovSync;
      supUv_ff <= (supUv_ff && !supplyClear) || uvSync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch drive.

  // Open load never turns a switch off; supply, overcurrent and mode do.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sw_ff <= 4'h0;
      supFault_ff <= 1'b0;
    end else if (clkEn) begin
      supFault_ff <= supplyCut;
      if (offMode || supplyCut || (supplyRelease && !recEn_ff)) begin
        sw_ff <= 4'h0;
      end else begin
        sw_ff <= demand & ~ocTrip;
      end
    end
  end

  // Mirror registers so every output leaves a flop.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfgOut_ff <= 12'h000;
      dutyAOut_ff <= 8'h00;
      dutyBOut_ff <= 8'h00;
      freqOut_ff <= 2'h0;
    end else if (clkEn) begin
      cfgOut_ff <= {cfg_ff[3], cfg_ff[2], cfg_ff[1], cfg_ff[0]};
      dutyAOut_ff <= dutyA_ff;
      dutyBOut_ff <= dutyB_ff;
      freqOut_ff <= freq_ff;
    end
  end

  assign outputSwitchN = sw_ff;
  assign overcurrentStatusReg = oc_ff;
  assign openLoadStatusReg = ol_ff;
  assign supplyOvervoltageFlag = supOv_ff;
  assign supplyUndervoltageFlag = supUv_ff;
  assign outputConfigState = cfgOut_ff;
  assign pulseGenADutyOut = dutyAOut_ff;
  assign pulseGenBDutyOut = dutyBOut_ff;
  assign pulseGenFrequencySelect = freqOut_ff;

endmodule

// File: hss_loads.sv
// Behavioural loads on the four switched outputs.
module hss_loads (
  input wire logic [3:0] outputSwitchN,
  input wire logic [3:0] shortLoad,
  input wire logic [3:0] openLoad,
  output logic [3:0] overCurrentRaw,
  output logic [3:0] underCurrentRaw
);
  timeunit 1ns;
  timeprecision 1ps;
  // A load draws current only while its switch conducts.
  assign overCurrentRaw = outputSwitchN & shortLoad;
  assign underCurrentRaw = outputSwitchN & openLoad;
endmodule

// File: hss_sva.sv
// Watches the switch controller at its ports.
module hss_sva (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire hss_pkg::mode_type devMode,
  input wire logic ctlWrite,
  input wire logic ovCutoffDisable,
  input wire logic uvCutoffDisable,
  input wire logic recoveryEnable,
  input wire logic supplyOvRaw,
  input wire logic supplyUvRaw,
  input wire logic ocClear,
  input wire logic olClear,
  input wire logic [3:0] outputSwitchN,
  input wire logic [3:0] overcurrentStatusReg,
  input wire logic [3:0] openLoadStatusReg,
  input wire logic supplyOvervoltageFlag,
  input wire logic [11:0] outputConfigState,
  input wire logic [7:0] pulseGenBDutyOut,
  input wire logic [1:0] pulseGenFrequencySelect
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ovDis_ff;
  logic uvDis_ff;
  logic recEn_ff;
  logic ctlTake;
  ////////////////////////////////////////
  // Shadow copy of the cutoff disable bits, loaded as a normal-mode write.
  assign ctlTake = ctlWrite && clkEn && devMode == hss_pkg::MODE_NORMAL;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovDis_ff <= 1'h0;
      uvDis_ff <= 1'h0;
      recEn_ff <= 1'h0;
    end else if (ctlTake) begin
      ovDis_ff <= ovCutoffDisable;
      uvDis_ff <= uvCutoffDisable;
      recEn_ff <= recoveryEnable;
    end
  end
  ////////////////////////////////////////
  // All checks share one clock and the reset.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence ovHeld;
    (supplyOvRaw && !ovDis_ff && clkEn) [*5];
  endsequence
  sequence uvHeld;
    (supplyUvRaw && !uvDis_ff && clkEn) [*5];
  endsequence
  a_ov_forces_off: assert property (ovHeld |=> outputSwitchN == 4'h0)
    else $error("outputs on during overvoltage");
  a_uv_forces_off: assert property (uvHeld |=> outputSwitchN == 4'h0)
    else $error("outputs on during undervoltage");
  a_norecover_stays_off: assert property (uvHeld ##1 (!supplyUvRaw && !recEn_ff) |=>
    (outputSwitchN == 4'h0) [*8])
    else $error("output back on without recovery");
  a_ov_flag_set: assert property ((supplyOvRaw && clkEn) [*4] |=> supplyOvervoltageFlag)
    else $error("overvoltage flag not set");
  a_oc_flag_sticky: assert property (!ocClear |=>
    (overcurrentStatusReg & $past(overcurrentStatusReg)) == $past(overcurrentStatusReg))
    else $error("overcurrent flag dropped");
  a_ol_flag_sticky: assert property (!olClear |=>
    (openLoadStatusReg & $past(openLoadStatusReg)) == $past(openLoadStatusReg))
    else $error("open load flag dropped");
  a_oc_clears_config: assert property ($rose(overcurrentStatusReg[0]) |->
    !outputSwitchN[0] ##1 outputConfigState[2:0] == 3'h0)
    else $error("overcurrent did not clear output");
  a_ol_stays_on: assert property ($rose(openLoadStatusReg[1]) |-> outputSwitchN[1])
    else $error("open load switched output off");
  a_fault_mode_off: assert property ((devMode == hss_pkg::MODE_RESTART ||
    devMode == hss_pkg::MODE_FAILSAFE) [*3] |-> outputSwitchN == 4'h0)
    else $error("outputs on in restart or fail-safe");
  a_lowpower_locked: assert property ((devMode == hss_pkg::MODE_STOP ||
    devMode == hss_pkg::MODE_SLEEP) [*3] |-> $stable(pulseGenBDutyOut) && $stable(pulseGenFrequencySelect))
    else $error("settings changed in low power mode");
endmodule

bind high_side_switch_control hss_sva sva (.*);

// File: high_side_switch_control_tb.sv
// Self-checking bench for the high-side switch controller.
module high_side_switch_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
  logic ref_clk = 1'h0, sys_rst = 1'h1, clkEn = 1'h1, cfgWrite = 1'h0, dutyWriteA = 1'h0, dutyWriteB = 1'h0;
  logic freqWrite = 1'h0, ctlWrite = 1'h0, ovCutoffDisable = 1'h0, uvCutoffDisable = 1'h0, recoveryEnable = 1'h1;
  logic ocClear = 1'h0, olClear = 1'h0, supplyClear = 1'h0, timer1In = 1'h0, timer2In = 1'h0;
  logic supplyOvRaw = 1'h0, supplyUvRaw = 1'h0, supplyOvervoltageFlag, supplyUndervoltageFlag;
  logic [1:0] cfgSel = 2'h0, freqData = 2'h0, pulseGenFrequencySelect;
  logic [2:0] cfgData = 3'h0;
  logic [7:0] dutyData = 8'h00, pulseGenADutyOut, pulseGenBDutyOut;
  logic [3:0] ocClearMask = 4'h0, olClearMask = 4'h0, shortLoad = 4'h0, openLoad = 4'h0;
  logic [3:0] overCurrentRaw, underCurrentRaw, outputSwitchN, overcurrentStatusReg, openLoadStatusReg;
  logic [11:0] outputConfigState;
  hss_pkg::mode_type devMode = hss_pkg::MODE_NORMAL;
  int error_cnt = 0, tests_run = 0, cyc = 0;

  high_side_switch_control dut (.*);
  hss_loads loads (.*);
  ////////////////////////////////////////
  // Clock, and a cycle count from reset release.
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= sys_rst ? 0 : cyc + 1;
  // Access tasks drive on the falling edge and pulse strobes for one cycle.
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic cfg(input logic [1:0] s, input logic [2:0] c);
    @(negedge ref_clk);
    {cfgSel, cfgData, cfgWrite} = {s, c, 1'h1};
    @(negedge ref_clk);
    cfgWrite = 1'h0;
  endtask
  task automatic duty(input logic b, input logic [7:0] d);
    @(negedge ref_clk);
    {dutyData, dutyWriteA, dutyWriteB} = {d, !b, b};
    @(negedge ref_clk);
    {dutyWriteA, dutyWriteB} = 2'h0;
  endtask
  task automatic ctl(input logic ovd, input logic uvd, input logic rec);
    @(negedge ref_clk);
    {ovCutoffDisable, uvCutoffDisable, recoveryEnable, ctlWrite} = {ovd, uvd, rec, 1'h1};
    @(negedge ref_clk);
    ctlWrite = 1'h0;
  endtask
  task automatic clr(input logic [3:0] oc, input logic [3:0] ol, input logic sup);
    @(negedge ref_clk);
    {ocClearMask, olClearMask, ocClear, olClear, supplyClear} = {oc, ol, |oc, |ol, sup};
    @(negedge ref_clk);
    {ocClear, olClear, supplyClear} = 3'h0;
  endtask
  task automatic endt(input string s);
    $display("test %s finished", s);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog cuts a hang short.
  initial begin
    repeat (60000) @(posedge ref_clk);
    error_cnt++;
    close_out();
  end
  ////////////////////////////////////////
  // Test sequence.
  initial begin
    wt(5);
    sys_rst = 1'h0;
    @(negedge ref_clk);
    {freqData, freqWrite} = {2'h1, 1'h1};
    @(negedge ref_clk);
    freqWrite = 1'h0;
    duty(1'h0, 8'h03);
    duty(1'h1, 8'h03);
    cfg(2'h0, hss_pkg::CFG_PWM1);
    cfg(2'h1, hss_pkg::CFG_PWM2);
    wait (cyc == hss_pkg::STEP_FAST_CYC);
    wt(1);
    `CHK("pwm start", 2'h3, outputSwitchN[1:0])
    wait (cyc == (3 * hss_pkg::STEP_FAST_CYC + 3 * hss_pkg::STEP_SLOW_CYC) / 2);
    wt(1);
    `CHK("pwm rate", 2'h2, outputSwitchN[1:0])
    `CHK("freq sel", 2'h1, pulseGenFrequencySelect)
    duty(1'h0, 8'hff);
    wt(3);
    `CHK("pwm duty", 2'h3, outputSwitchN[1:0])
    endt("pwm");
    cfg(2'h2, hss_pkg::CFG_TIMER1);
    cfg(2'h3, hss_pkg::CFG_TIMER2);
    timer1In = 1'h1;
    wt(3);
    `CHK("timer1", 2'h1, outputSwitchN[3:2])
    {timer1In, timer2In} = 2'h1;
    wt(3);
    `CHK("timer2", 2'h2, outputSwitchN[3:2])
    cfg(2'h3, 3'h6);
    cfg(2'h1, hss_pkg::CFG_OFF);
    cfg(2'h0, hss_pkg::CFG_ON);
    wt(2);
    `CHK("on off", 4'h1, outputSwitchN)
    endt("select");
    shortLoad = 4'h1;
    wt(hss_pkg::OC_FILTER_CYC - 100);
    `CHK("oc filter", 1'h1, outputSwitchN[0])
    wt(200);
    `CHK("oc off", 5'h02, {overcurrentStatusReg, outputSwitchN[0]})
    `CHK("oc cfg", 3'h0, outputConfigState[2:0])
    shortLoad = 4'h0;
    cfg(2'h0, hss_pkg::CFG_ON);
    wt(2);
    `CHK("oc kept", 5'h03, {overcurrentStatusReg, outputSwitchN[0]})
    clr(4'h1, 4'h0, 1'h0);
    `CHK("oc clear", 4'h0, overcurrentStatusReg)
    endt("overcurrent");
    cfg(2'h1, hss_pkg::CFG_ON);
    openLoad = 4'h2;
    wt(hss_pkg::OL_FILTER_CYC + 100);
    `CHK("ol set", 8'h23, {openLoadStatusReg, outputSwitchN})
    openLoad = 4'h0;
    wt(5);
    `CHK("ol kept", 4'h2, openLoadStatusReg)
    clr(4'h0, 4'h2, 1'h0);
    `CHK("ol clear", 4'h0, openLoadStatusReg)
    endt("open load");
    ctl(1'h0, 1'h0, 1'h1);
    supplyOvRaw = 1'h1;
    wt(6);
    `CHK("ov off", 4'h0, outputSwitchN)
    `CHK("ov flags", 10'h200, {supplyOvervoltageFlag, supplyUndervoltageFlag, overcurrentStatusReg, openLoadStatusReg})
    supplyOvRaw = 1'h0;
    wt(6);
    `CHK("ov back", 4'h3, outputSwitchN)
    ctl(1'h0, 1'h0, 1'h0);
    supplyUvRaw = 1'h1;
    wt(6);
    `CHK("uv off", 5'h10, {supplyUndervoltageFlag, outputSwitchN})
    supplyUvRaw = 1'h0;
    wt(6);
    `CHK("uv stay", 16'h0, {outputSwitchN, outputConfigState})
    ctl(1'h1, 1'h0, 1'h1);
    cfg(2'h0, hss_pkg::CFG_ON);
    supplyOvRaw = 1'h1;
    wt(6);
    `CHK("ov disabled", 4'h1, outputSwitchN)
    supplyOvRaw = 1'h0;
    wt(3);
    clr(4'h0, 4'h0, 1'h1);
    wt(1);
    `CHK("sup clear", 2'h0, {supplyOvervoltageFlag, supplyUndervoltageFlag})
    endt("supply");
    devMode = hss_pkg::MODE_STOP;
    cfg(2'h0, hss_pkg::CFG_OFF);
    duty(1'h1, 8'h55);
    wt(2);
    `CHK("stop lock", 12'h903, {outputSwitchN[0], outputConfigState[2:0], pulseGenBDutyOut})
    devMode = hss_pkg::MODE_SLEEP;
    shortLoad = 4'h1;
    wt(hss_pkg::OC_FILTER_CYC + 100);
    `CHK("sleep oc", 2'h2, {overcurrentStatusReg[0], outputSwitchN[0]})
    shortLoad = 4'h0;
    devMode = hss_pkg::MODE_NORMAL;
    clr(4'h1, 4'h0, 1'h0);
    for (int i = 0; i < 2; i++) begin
      cfg(2'h0, hss_pkg::CFG_ON);
      wt(2);
      devMode = i ? hss_pkg::MODE_FAILSAFE : hss_pkg::MODE_RESTART;
      wt(3);
      `CHK("fault mode", 4'h0, outputSwitchN)
      devMode = hss_pkg::MODE_NORMAL;
      wt(2);
      `CHK("fault stays off", 4'h0, outputSwitchN)
    end
    endt("modes");
    close_out();
  end
endmodule
